// ==== design/pgts_gate_trig.sv ====
`timescale 1ns/1ps
`default_nettype none
module pgts_gate_trig (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // channel inputs, comparator outputs and routed backplane lines
   input wire logic fp_a_cmp,
   input wire logic fp_b_cmp,
   input wire logic bp_a_in,
   input wire logic bp_b_in,
   // gate and trigger configuration
   input wire logic gate_en,
   input wire logic gate_async,
   input wire logic [3:0] gate_sel,
   input wire logic [3:0] trig_sel,
   // run controls (run_n low means run)
   input wire logic run_n,
   input wire logic out_en,
   // pulse generator status
   input wire logic pulse_active,
   // reference configuration
   input wire logic [1:0] ref_rate_sel,
   input wire logic [1:0] ref_src_sel,
   // front input thresholds
   input wire logic [11:0] thr_a_set,
   input wire logic [11:0] thr_b_set,
   input wire logic [11:0] hys_set,
   input wire logic dac_direct,
   input wire logic [11:0] dac_a_code,
   input wire logic [11:0] dac_b_code,
   input wire logic thr_load,
   // frequency generation mode
   input wire logic [1:0] fgen_mode_sel,
   // outputs to pulse channel
   output logic pulse_channel_trig,
   output logic pulse_channel_gate,
   output logic pulse_channel_run,
   // reference outputs
   output logic ref_en,
   output logic [1:0] ref_rate,
   output logic ref_clk,
   // converter codes
   output logic [11:0] dac_a,
   output logic [11:0] dac_b,
   output logic [11:0] dac_hys,
   // frequency path selection
   output logic dds_only,
   output logic dds_div
);
   logic [pgts_pkg::NUM_IN-1:0] raw_in;
   logic [pgts_pkg::NUM_IN-1:0] s_in;
   logic [pgts_pkg::NUM_IN-1:0] prev_reg;
   logic run_reg;
   logic gate_reg, gate_next;
   logic trig_reg, trig_next;
   logic chrun_reg, chrun_next;
   logic ref_en_reg, ref_clk_reg;
   logic [1:0] ref_rate_reg;
   logic [11:0] dac_a_reg, dac_b_reg, hys_reg;
   logic dds_only_reg, dds_div_reg;

   // both front comparator pins and both backplane lines, one bit each
   assign raw_in = {bp_b_in, bp_a_in, fp_b_cmp, fp_a_cmp};

   pgts_sync u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(raw_in),
      .sync_out(s_in)
   );

   wire [pgts_pkg::NUM_IN-1:0] rise = s_in & ~prev_reg;
   wire [pgts_pkg::NUM_IN-1:0] fall = ~s_in & prev_reg;
   wire run_cmd = ~run_n & out_en;

   function automatic logic level_ok(input logic [3:0] sel, input logic [pgts_pkg::NUM_IN-1:0] lv);
      unique case (sel)
         pgts_pkg::GATE_FPA_HI: level_ok = lv[pgts_pkg::IN_FPA];
         pgts_pkg::GATE_FPA_LO: level_ok = ~lv[pgts_pkg::IN_FPA];
         pgts_pkg::GATE_FPB_HI: level_ok = lv[pgts_pkg::IN_FPB];
         pgts_pkg::GATE_FPB_LO: level_ok = ~lv[pgts_pkg::IN_FPB];
         pgts_pkg::GATE_BPA_HI: level_ok = lv[pgts_pkg::IN_BPA];
         pgts_pkg::GATE_BPA_LO: level_ok = ~lv[pgts_pkg::IN_BPA];
         pgts_pkg::GATE_BPB_HI: level_ok = lv[pgts_pkg::IN_BPB];
         pgts_pkg::GATE_BPB_LO: level_ok = ~lv[pgts_pkg::IN_BPB];
         default: level_ok = 1'b1;
      endcase
   endfunction

   wire gate_open = ~gate_en | level_ok(gate_sel, s_in);
   // synchronous mode holds gate open while a pulse is in progress
   assign gate_next = gate_open | (~gate_async & gate_reg & pulse_active);

   wire edge_hit =
      (trig_sel == pgts_pkg::TRIG_FPA_RISE && rise[pgts_pkg::IN_FPA]) ||
      (trig_sel == pgts_pkg::TRIG_FPA_FALL && fall[pgts_pkg::IN_FPA]) ||
      (trig_sel == pgts_pkg::TRIG_FPB_RISE && rise[pgts_pkg::IN_FPB]) ||
      (trig_sel == pgts_pkg::TRIG_FPB_FALL && fall[pgts_pkg::IN_FPB]) ||
      (trig_sel == pgts_pkg::TRIG_BPA_RISE && rise[pgts_pkg::IN_BPA]) ||
      (trig_sel == pgts_pkg::TRIG_BPA_FALL && fall[pgts_pkg::IN_BPA]) ||
      (trig_sel == pgts_pkg::TRIG_BPB_RISE && rise[pgts_pkg::IN_BPB]) ||
      (trig_sel == pgts_pkg::TRIG_BPB_FALL && fall[pgts_pkg::IN_BPB]);
   wire soft_hit = (trig_sel == pgts_pkg::TRIG_SOFT) && run_cmd && !run_reg;
   assign trig_next = run_cmd & (soft_hit | edge_hit);
   assign chrun_next = run_cmd;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_reg <= '0;
         run_reg <= 1'b0;
         gate_reg <= 1'b1;
         trig_reg <= 1'b0;
         chrun_reg <= 1'b0;
      end else begin
         prev_reg <= s_in;
         run_reg <= run_cmd;
         gate_reg <= gate_next;
         trig_reg <= trig_next;
         chrun_reg <= chrun_next;
      end
   end

   // reference enable, rate and source
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_en_reg <= 1'b0;
         ref_rate_reg <= pgts_pkg::REF_OFF;
         ref_clk_reg <= 1'b0;
      end else begin
         ref_en_reg <= (ref_rate_sel != pgts_pkg::REF_OFF);
         ref_rate_reg <= ref_rate_sel;
         ref_clk_reg <= (ref_rate_sel != pgts_pkg::REF_OFF) & s_in[ref_src_sel];
      end
   end

   // threshold codes, loaded on request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dac_a_reg <= pgts_pkg::THR_RST;
         dac_b_reg <= pgts_pkg::THR_RST;
         hys_reg <= pgts_pkg::HYS_RST;
      end else if (thr_load) begin
         dac_a_reg <= dac_direct ? dac_a_code : thr_a_set;
         dac_b_reg <= dac_direct ? dac_b_code : thr_b_set;
         hys_reg <= hys_set;
      end
   end

   // frequency path: auto leaves both selects low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dds_only_reg <= 1'b0;
         dds_div_reg <= 1'b0;
      end else begin
         dds_only_reg <= (fgen_mode_sel == pgts_pkg::FGEN_DDS);
         dds_div_reg <= (fgen_mode_sel == pgts_pkg::FGEN_DDS_DIV);
      end
   end

   assign pulse_channel_trig = trig_reg;
   assign pulse_channel_gate = gate_reg;
   assign pulse_channel_run = chrun_reg;
   assign ref_en = ref_en_reg;
   assign ref_rate = ref_rate_reg;
   assign ref_clk = ref_clk_reg;
   assign dac_a = dac_a_reg;
   assign dac_b = dac_b_reg;
   assign dac_hys = hys_reg;
   assign dds_only = dds_only_reg;
   assign dds_div = dds_div_reg;

   // assertions
   property p_ignore_open;
      @(posedge clk) disable iff (!rst_n)
      (gate_sel == pgts_pkg::GATE_IGNORE || !gate_en) |=> pulse_channel_gate;
   endproperty
   a_ignore_open: assert property (p_ignore_open) else $error("gate closed while ignored");

   property p_fpa_hi;
      @(posedge clk) disable iff (!rst_n)
      (gate_en && gate_async && gate_sel == pgts_pkg::GATE_FPA_HI) |=> (pulse_channel_gate == $past(s_in[0]));
   endproperty
   a_fpa_hi: assert property (p_fpa_hi) else $error("front A high gate wrong");

   property p_bpb_lo;
      @(posedge clk) disable iff (!rst_n)
      (gate_en && gate_async && gate_sel == pgts_pkg::GATE_BPB_LO) |=> (pulse_channel_gate == !$past(s_in[3]));
   endproperty
   a_bpb_lo: assert property (p_bpb_lo) else $error("backplane B low gate wrong");

   property p_soft;
      @(posedge clk) disable iff (!rst_n)
      (trig_sel == pgts_pkg::TRIG_SOFT && run_cmd && !run_reg) |=> pulse_channel_trig;
   endproperty
   a_soft: assert property (p_soft) else $error("soft trigger missed");

   property p_fpa_rise;
      @(posedge clk) disable iff (!rst_n)
      (trig_sel == pgts_pkg::TRIG_FPA_RISE && run_cmd && s_in[0] && !prev_reg[0]) |=> pulse_channel_trig;
   endproperty
   a_fpa_rise: assert property (p_fpa_rise) else $error("front A rise missed");

   property p_bpa_fall;
      @(posedge clk) disable iff (!rst_n)
      (trig_sel == pgts_pkg::TRIG_BPA_FALL && run_cmd && !s_in[2] && prev_reg[2]) |=> pulse_channel_trig;
   endproperty
   a_bpa_fall: assert property (p_bpa_fall) else $error("backplane A fall missed");

   property p_no_trig_idle;
      @(posedge clk) disable iff (!rst_n)
      !run_cmd |=> !pulse_channel_trig;
   endproperty
   a_no_trig_idle: assert property (p_no_trig_idle) else $error("trigger while not running");

   property p_sync_hold;
      @(posedge clk) disable iff (!rst_n)
      (!gate_async && pulse_channel_gate && pulse_active) |=> pulse_channel_gate;
   endproperty
   a_sync_hold: assert property (p_sync_hold) else $error("sync gate cut a pulse");

   property p_ref_off;
      @(posedge clk) disable iff (!rst_n)
      (ref_rate_sel == pgts_pkg::REF_OFF) |=> (!ref_en && !ref_clk);
   endproperty
   a_ref_off: assert property (p_ref_off) else $error("reference active while off");

   property p_sync_lat;
      @(posedge clk) disable iff (!rst_n)
      $rose(bp_a_in) ##1 bp_a_in ##1 bp_a_in |-> s_in[2];
   endproperty
   a_sync_lat: assert property (p_sync_lat) else $error("synchroniser latency wrong");

   property p_fpb_lo;
      @(posedge clk) disable iff (!rst_n)
      (gate_en && gate_async && gate_sel == pgts_pkg::GATE_FPB_LO) |=> (pulse_channel_gate == !$past(s_in[1]));
   endproperty
   a_fpb_lo: assert property (p_fpb_lo) else $error("front B low gate wrong");

   property p_bpa_hi;
      @(posedge clk) disable iff (!rst_n)
      (gate_en && gate_async && gate_sel == pgts_pkg::GATE_BPA_HI) |=> (pulse_channel_gate == $past(s_in[2]));
   endproperty
   a_bpa_hi: assert property (p_bpa_hi) else $error("backplane A high gate wrong");

   property p_fpb_fall;
      @(posedge clk) disable iff (!rst_n)
      (trig_sel == pgts_pkg::TRIG_FPB_FALL && run_cmd && !s_in[1] && prev_reg[1]) |=> pulse_channel_trig;
   endproperty
   a_fpb_fall: assert property (p_fpb_fall) else $error("front B fall missed");

   property p_bpa_rise;
      @(posedge clk) disable iff (!rst_n)
      (trig_sel == pgts_pkg::TRIG_BPA_RISE && run_cmd && s_in[2] && !prev_reg[2]) |=> pulse_channel_trig;
   endproperty
   a_bpa_rise: assert property (p_bpa_rise) else $error("backplane A rise missed");

   property p_bpb_fall;
      @(posedge clk) disable iff (!rst_n)
      (trig_sel == pgts_pkg::TRIG_BPB_FALL && run_cmd && !s_in[3] && prev_reg[3]) |=> pulse_channel_trig;
   endproperty
   a_bpb_fall: assert property (p_bpb_fall) else $error("backplane B fall missed");

   property p_run_follow;
      @(posedge clk) disable iff (!rst_n)
      1'b1 |=> (pulse_channel_run == $past(run_cmd));
   endproperty
   a_run_follow: assert property (p_run_follow) else $error("run output not following run and enable");

   property p_async_close;
      @(posedge clk) disable iff (!rst_n)
      (gate_en && gate_async && pulse_active && gate_sel == pgts_pkg::GATE_FPA_HI && !s_in[0])
         |=> !pulse_channel_gate;
   endproperty
   a_async_close: assert property (p_async_close) else $error("async gate held open by a pulse");

   property p_ref_on;
      @(posedge clk) disable iff (!rst_n)
      (ref_rate_sel != pgts_pkg::REF_OFF) |=> (ref_en && ref_rate == $past(ref_rate_sel));
   endproperty
   a_ref_on: assert property (p_ref_on) else $error("reference rate not taken");

   property p_ref_src;
      @(posedge clk) disable iff (!rst_n)
      (ref_rate_sel != pgts_pkg::REF_OFF) |=> (ref_clk == $past(s_in[ref_src_sel]));
   endproperty
   a_ref_src: assert property (p_ref_src) else $error("reference source wrong");

   property p_thr_hold;
      @(posedge clk) disable iff (!rst_n)
      !thr_load |=> ($stable(dac_a) && $stable(dac_b) && $stable(dac_hys));
   endproperty
   a_thr_hold: assert property (p_thr_hold) else $error("converter code changed without load");

   property p_fgen_auto;
      @(posedge clk) disable iff (!rst_n)
      (fgen_mode_sel == pgts_pkg::FGEN_AUTO) |=> (!dds_only && !dds_div);
   endproperty
   a_fgen_auto: assert property (p_fgen_auto) else $error("auto mode selected a fixed path");
endmodule // pgts_gate_trig
`default_nettype wire

// ==== design/pgts_pkg.sv ====
package pgts_pkg;
   // gate source selection codes
   localparam logic [3:0] GATE_IGNORE = 4'h0;
   localparam logic [3:0] GATE_FPA_HI = 4'h1;
   localparam logic [3:0] GATE_FPA_LO = 4'h2;
   localparam logic [3:0] GATE_FPB_HI = 4'h3;
   localparam logic [3:0] GATE_FPB_LO = 4'h4;
   localparam logic [3:0] GATE_BPA_HI = 4'h5;
   localparam logic [3:0] GATE_BPA_LO = 4'h6;
   localparam logic [3:0] GATE_BPB_HI = 4'h7;
   localparam logic [3:0] GATE_BPB_LO = 4'h8;
   // trigger selection codes
   localparam logic [3:0] TRIG_SOFT = 4'h0;
   localparam logic [3:0] TRIG_FPA_RISE = 4'h1;
   localparam logic [3:0] TRIG_FPA_FALL = 4'h2;
   localparam logic [3:0] TRIG_FPB_RISE = 4'h3;
   localparam logic [3:0] TRIG_FPB_FALL = 4'h4;
   localparam logic [3:0] TRIG_BPA_RISE = 4'h5;
   localparam logic [3:0] TRIG_BPA_FALL = 4'h6;
   localparam logic [3:0] TRIG_BPB_RISE = 4'h7;
   localparam logic [3:0] TRIG_BPB_FALL = 4'h8;
   // reference rate codes
   localparam logic [1:0] REF_OFF = 2'h0;
   localparam logic [1:0] REF_100PPS = 2'h1;
   localparam logic [1:0] REF_10MHZ = 2'h2;
   localparam logic [1:0] REF_1PPS = 2'h3;
   // reference source codes
   localparam logic [1:0] RSRC_FPA = 2'h0;
   localparam logic [1:0] RSRC_FPB = 2'h1;
   localparam logic [1:0] RSRC_BPA = 2'h2;
   localparam logic [1:0] RSRC_BPB = 2'h3;
   // frequency generation modes
   localparam logic [1:0] FGEN_AUTO = 2'h0;
   localparam logic [1:0] FGEN_DDS = 2'h1;
   localparam logic [1:0] FGEN_DDS_DIV = 2'h2;
   // converter code widths and reset values, synchroniser depth and input count
   localparam int DAC_W = 12;
   localparam logic [11:0] THR_RST = 12'h800;
   localparam logic [11:0] HYS_RST = 12'h000;
   localparam int SYNC_STAGES = 2;
   localparam int NUM_IN = 4;
   // input index
   localparam int IN_FPA = 0;
   localparam int IN_FPB = 1;
   localparam int IN_BPA = 2;
   localparam int IN_BPB = 3;
endpackage

// ==== design/pgts_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pgts_sync (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // data
   input wire logic [pgts_pkg::NUM_IN-1:0] async_in,
   output logic [pgts_pkg::NUM_IN-1:0] sync_out
);
   logic [pgts_pkg::NUM_IN-1:0] meta_reg;
   logic [pgts_pkg::NUM_IN-1:0] sync_reg;

   // two-stage synchroniser per input
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;
endmodule // pgts_sync
`default_nettype wire

// ==== testbench/pgts_src.sv ====
`timescale 1ns/1ps
`default_nettype none
module pgts_src (
   // level commands from the bench
   input wire logic [3:0] lvl,
   // comparator and routed backplane lines
   output logic fp_a,
   output logic fp_b,
   output logic bp_a,
   output logic bp_b
);
   // odd skew keeps the lines unrelated in phase to the channel clock
   assign #1.3 {bp_b, bp_a, fp_b, fp_a} = lvl;
endmodule // pgts_src
`default_nettype wire

// ==== testbench/pulse_gate_trigger_select_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module pulse_gate_trigger_select_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] lvl = 4'h0;
   wire fpa, fpb, bpa, bpb;
   logic gate_en = 1'b0, gate_async = 1'b1, run_n = 1'b1, out_en = 1'b0;
   logic pulse_active = 1'b0, dac_direct = 1'b0, thr_load = 1'b0;
   logic [3:0] gate_sel = 4'h0, trig_sel = 4'h0;
   logic [1:0] ref_rate_sel = 2'h0, ref_src_sel = 2'h0, fgen_mode_sel = 2'h0;
   logic [11:0] thr_a_set = 12'h123, thr_b_set = 12'h456, hys_set = 12'h0a5;
   logic [11:0] dac_a_code = 12'h7e1, dac_b_code = 12'h3c2;
   logic trig, gate, run, ref_en, ref_clk, dds_only, dds_div;
   logic [1:0] ref_rate;
   logic [11:0] dac_a, dac_b, dac_hys;
   int mismatches = 0, total_checks = 0, trigs = 0, c, idx;
   logic rise;
   // rows: gate select, input levels, expected gate
   logic [11:0] rows [19] = '{12'h001, 12'h111, 12'h100, 12'h201, 12'h210, 12'h321, 12'h310, 12'h411,
      12'h541, 12'h530, 12'h631, 12'h640, 12'h781, 12'h770, 12'h871, 12'h880, 12'h901, 12'h420, 12'h1e0};

   pgts_src u_src (.lvl(lvl), .fp_a(fpa), .fp_b(fpb), .bp_a(bpa), .bp_b(bpb));

   pgts_gate_trig u_dut (.clk, .rst_n, .fp_a_cmp(fpa), .fp_b_cmp(fpb), .bp_a_in(bpa), .bp_b_in(bpb),
      .gate_en, .gate_async, .gate_sel, .trig_sel, .run_n, .out_en, .pulse_active, .ref_rate_sel,
      .ref_src_sel, .thr_a_set, .thr_b_set, .hys_set, .dac_direct, .dac_a_code, .dac_b_code, .thr_load,
      .fgen_mode_sel, .pulse_channel_trig(trig), .pulse_channel_gate(gate), .pulse_channel_run(run),
      .ref_en, .ref_rate, .ref_clk, .dac_a, .dac_b, .dac_hys, .dds_only, .dds_div);

   always #2.5 clk = ~clk;
   // counts trigger pulses seen at the sampling edge
   always @(posedge clk) if (trig === 1'b1) trigs++;

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic results;
      $display("mismatches=%0d total_checks=%0d", mismatches, total_checks);
      if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      #200000;
      mismatches++;
      results();
   end

   initial begin
      cyc(3);
      rst_n = 1'b1;
      cyc(1);
      chk({trig, gate, run, ref_en, dds_only, dds_div}, 12'h010);
      chk(dac_a, pgts_pkg::THR_RST);
      chk(dac_hys, pgts_pkg::HYS_RST);
      // gate level table, async mode
      gate_en = 1'b1;
      for (c = 0; c < 19; c++) begin
         gate_sel = rows[c][11:8];
         lvl = rows[c][7:4];
         cyc(6);
         chk(gate, rows[c][3:0]);
      end
      // gating switched off never blocks
      gate_en = 1'b0;
      gate_sel = pgts_pkg::GATE_FPA_HI;
      lvl = 4'h0;
      cyc(6);
      chk(gate, 12'h001);
      // inputs pass two flops before the gate register
      gate_en = 1'b1;
      cyc(6);
      lvl = 4'h1;
      cyc(2);
      chk(gate, 12'h000);
      cyc(1);
      chk(gate, 12'h001);
      // async gate closes despite a pulse in progress
      pulse_active = 1'b1;
      lvl = 4'h0;
      cyc(6);
      chk(gate, 12'h000);
      // sync gate waits for the pulse to finish
      gate_async = 1'b0;
      lvl = 4'h1;
      cyc(6);
      lvl = 4'h0;
      cyc(6);
      chk(gate, 12'h001);
      pulse_active = 1'b0;
      cyc(1);
      chk(gate, 12'h000);
      // software trigger
      trigs = 0;
      run_n = 1'b0;
      cyc(2);
      chk(trigs[11:0], 12'h000);
      out_en = 1'b1;
      cyc(1);
      chk(trig, 12'h001);
      cyc(5);
      chk(trigs[11:0], 12'h001);
      chk(run, 12'h001);
      // edge triggers, wanted edge then the opposite one
      for (c = 1; c < 9; c++) begin
         idx = (c - 1) >> 1;
         rise = c[0];
         lvl = rise ? 4'h0 : 4'h1 << idx;
         trig_sel = c[3:0];
         cyc(6);
         trigs = 0;
         lvl[idx] = rise;
         cyc(3);
         chk(trig, 12'h001);
         cyc(1);
         chk(trig, 12'h000);
         cyc(2);
         chk(trigs[11:0], 12'h001);
         lvl[idx] = ~rise;
         cyc(6);
         chk(trigs[11:0], 12'h001);
      end
      // back to back edges, then refusal without run
      trig_sel = pgts_pkg::TRIG_BPA_RISE;
      trigs = 0;
      repeat (4) begin
         lvl[2] = ~lvl[2];
         cyc(1);
      end
      cyc(6);
      chk(trigs[11:0], 12'h002);
      run_n = 1'b1;
      cyc(3);
      chk(run, 12'h000);
      trigs = 0;
      lvl[2] = 1'b1;
      cyc(6);
      chk(trigs[11:0], 12'h000);
      // reference rate and source
      for (c = 0; c < 4; c++) begin
         ref_rate_sel = c[1:0];
         cyc(3);
         chk({ref_en, ref_rate}, {c != 0, c[1:0]});
      end
      ref_rate_sel = pgts_pkg::REF_10MHZ;
      for (c = 0; c < 4; c++) begin
         ref_src_sel = c[1:0];
         lvl = 4'h1 << c;
         cyc(6);
         chk(ref_clk, 12'h001);
         lvl = ~lvl;
         cyc(6);
         chk(ref_clk, 12'h000);
      end
      ref_rate_sel = pgts_pkg::REF_OFF;
      lvl = 4'hf;
      cyc(6);
      chk({ref_en, ref_clk}, 12'h000);
      // thresholds load only on the load strobe
      thr_load = 1'b1;
      cyc(1);
      thr_load = 1'b0;
      thr_a_set = 12'hfff;
      cyc(2);
      chk(dac_a, 12'h123);
      chk(dac_b, 12'h456);
      chk(dac_hys, 12'h0a5);
      dac_direct = 1'b1;
      thr_load = 1'b1;
      cyc(1);
      thr_load = 1'b0;
      cyc(2);
      chk(dac_a, 12'h7e1);
      chk(dac_b, 12'h3c2);
      // frequency generation modes
      for (c = 0; c < 3; c++) begin
         fgen_mode_sel = c[1:0];
         cyc(3);
         chk({dds_only, dds_div}, {c == 1, c == 2});
      end
      // reset after the run has stopped returns the outputs to idle at once
      rst_n = 1'b0;
      #1;
      chk({trig, gate, run, ref_en, dds_only, dds_div}, 12'h010);
      chk(dac_a, pgts_pkg::THR_RST);
      cyc(3);
      rst_n = 1'b1;
      cyc(2);
      chk({dds_only, dds_div, dac_b == pgts_pkg::THR_RST}, 12'h003);
      results();
   end
endmodule // pulse_gate_trigger_select_tb
`default_nettype wire
